// File: core/iarb_top.sv
// interrupt latch, fixed priority arbiter and vector selector
// What this block does
// - latch pending requests and arbitrate at start of processing, giving a fixed vector index.
// - once latched, no other request displaces it until serviced, then a return or a clear mask.
// - requests are only acted upon at instruction boundaries, never mid instruction.
// - at boundary, enter processing for a hardware request only if mask clear and source enabled.
// - among several enabled pending requests, grant highest fixed priority.
// - request still pending at return is serviced before next instruction; prefetch discarded.
// - interrupt entry stacking omits the high index register.
// - software interrupt is taken regardless of the global mask.
// - software interrupt stacks pc unchanged, hardware interrupt stacks pc minus one.
// - status flag reads one while its source requests, zero otherwise.
// - low status register bits one and zero read zero; flags one to six above.
// - priority: reset, software interrupt, then flag one down to flag twenty one.
// - vectors: reset FFFE, swi FFFC, flag n at FFFA minus two times n-1.
// - reset outranks everything and is never arbitrated against requests.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module iarb_top
  import iarb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [20:0] irq_req,
  input wire logic global_mask,
  input wire logic instr_boundary,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic service_ack,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic int_take,
  output logic [15:0] vector_addr,
  output logic [4:0] grant_idx,
  output logic grant_is_swi,
  output logic [15:0] stack_pc,
  output logic stack_index_high,
  output logic discard_prefetch,
  output logic irq_out
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // vector of flag n, n from 1
  function automatic logic [15:0] iarb_vec(input logic [4:0] n);
    logic [15:0] off;
    off = {10'h000, n, 1'b0} - 16'h0002;
    iarb_vec = IARB_VEC_FLAG1 - off;
  endfunction

  // lowest set bit index plus one, zero if none
  function automatic logic [4:0] iarb_pick(input logic [20:0] v);
    logic [4:0] r;
    r = IARB_IDX_NONE;
    for (int i = IARB_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i + 1);
      end
    end
    iarb_pick = r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  iarb_state_type state_r, state_nxt;
  logic [4:0] latch_idx_r, latch_idx_nxt;
  logic latch_swi_r, latch_swi_nxt;
  logic [20:0] enable_r, enable_nxt;
  logic [20:0] flags_r, flags_nxt;
  logic [1:0] evt_r, evt_nxt;
  logic [1:0] evt_mask_r, evt_mask_nxt;
  logic [7:0] rdata_nxt;
  logic int_take_nxt;
  logic [15:0] vector_nxt;
  logic [15:0] stack_pc_nxt;
  logic discard_nxt;
  logic irq_nxt;
  logic rti_seen_r, rti_seen_nxt;
  logic [20:0] eligible;
  logic [4:0] pick;

  always_comb begin
    // flags trail the request lines by one cycle
    flags_nxt = irq_req;
    eligible = flags_r & enable_r;
    pick = iarb_pick(eligible);
    state_nxt = state_r;
    latch_idx_nxt = latch_idx_r;
    latch_swi_nxt = latch_swi_r;
    int_take_nxt = 1'b0;
    vector_nxt = vector_addr;
    stack_pc_nxt = stack_pc;
    discard_nxt = 1'b0;
    rti_seen_nxt = rti_seen_r;
    // a return since the last boundary makes the refetched opcode redundant
    if (rti_exec) begin
      rti_seen_nxt = 1'b1;
    end
    unique case (state_r)
      IARB_IDLE: begin
        if (instr_boundary) begin
          if (swi_exec) begin
            state_nxt = IARB_LATCHED;
            latch_swi_nxt = 1'b1;
            latch_idx_nxt = IARB_IDX_NONE;
            vector_nxt = IARB_VEC_SWI;
            stack_pc_nxt = pc_in;
            int_take_nxt = 1'b1;
            discard_nxt = rti_seen_r;
            rti_seen_nxt = 1'b0;
          end else if (!global_mask && pick != IARB_IDX_NONE) begin
            state_nxt = IARB_LATCHED;
            latch_swi_nxt = 1'b0;
            latch_idx_nxt = pick;
            vector_nxt = iarb_vec(pick);
            stack_pc_nxt = pc_in - 16'h0001;
            int_take_nxt = 1'b1;
            discard_nxt = rti_seen_r;
            rti_seen_nxt = 1'b0;
          end else begin
            rti_seen_nxt = 1'b0;
          end
        end
      end
      IARB_LATCHED: begin
        // held result; higher requests ignored
        if (service_ack) begin
          state_nxt = IARB_SERVICE;
        end else if (!latch_swi_r && !global_mask && !instr_boundary) begin
          state_nxt = IARB_LATCHED;
        end
      end
      IARB_SERVICE: begin
        // a cleared global mask also frees the latch
        if (rti_exec || !global_mask) begin
          state_nxt = IARB_IDLE;
        end
      end
      default: state_nxt = IARB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= IARB_IDLE;
      latch_idx_r <= IARB_IDX_NONE;
      latch_swi_r <= 1'b0;
      flags_r <= IARB_ENABLE_RESET;
      rti_seen_r <= 1'b0;
      int_take <= 1'b0;
      vector_addr <= IARB_VEC_RESET;
      stack_pc <= IARB_PC_RESET;
      discard_prefetch <= 1'b0;
    end else begin
      state_r <= state_nxt;
      latch_idx_r <= latch_idx_nxt;
      latch_swi_r <= latch_swi_nxt;
      flags_r <= flags_nxt;
      rti_seen_r <= rti_seen_nxt;
      int_take <= int_take_nxt;
      vector_addr <= vector_nxt;
      stack_pc <= stack_pc_nxt;
      discard_prefetch <= discard_nxt;
    end
  end

  // ----------------------------------------
  // registers and events
  // ----------------------------------------
  always_comb begin
    enable_nxt = enable_r;
    evt_mask_nxt = evt_mask_r;
    evt_nxt = evt_r;
    if (reg_wr) begin
      unique case (reg_addr)
        IARB_OFS_ENABLE_0: enable_nxt[7:0] = reg_wdata;
        IARB_OFS_ENABLE_1: enable_nxt[15:8] = reg_wdata;
        IARB_OFS_ENABLE_2: enable_nxt[20:16] = reg_wdata[4:0];
        IARB_OFS_EVT_MASK: evt_mask_nxt = reg_wdata[1:0];
        IARB_OFS_EVT_STATUS: evt_nxt = evt_r & ~reg_wdata[1:0];
        default: ; // status writes ignored
      endcase
    end
    // set wins over clear
    if (int_take_nxt && !latch_swi_nxt) begin
      evt_nxt[IARB_EVT_GRANT_BIT] = 1'b1;
    end
    if (int_take_nxt && latch_swi_nxt) begin
      evt_nxt[IARB_EVT_SWI_BIT] = 1'b1;
    end
    irq_nxt = |(evt_nxt & evt_mask_nxt);
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        IARB_OFS_STATUS_LOW: rdata_nxt = {flags_r[5:0], 2'b00};
        IARB_OFS_STATUS_MID: rdata_nxt = flags_r[13:6];
        IARB_OFS_STATUS_HIGH: rdata_nxt = {1'b0, flags_r[20:14]};
        IARB_OFS_ENABLE_0: rdata_nxt = enable_r[7:0];
        IARB_OFS_ENABLE_1: rdata_nxt = enable_r[15:8];
        IARB_OFS_ENABLE_2: rdata_nxt = {3'b000, enable_r[20:16]};
        IARB_OFS_EVT_STATUS: rdata_nxt = {6'h00, evt_r};
        IARB_OFS_EVT_MASK: rdata_nxt = {6'h00, evt_mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enable_r <= IARB_ENABLE_RESET;
      evt_r <= 2'b00;
      evt_mask_r <= 2'b00;
      reg_rdata <= IARB_EVT_RESET;
      irq_out <= 1'b0;
      grant_idx <= IARB_IDX_NONE;
      grant_is_swi <= 1'b0;
      stack_index_high <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      evt_r <= evt_nxt;
      evt_mask_r <= evt_mask_nxt;
      reg_rdata <= rdata_nxt;
      irq_out <= irq_nxt;
      grant_idx <= latch_idx_nxt;
      grant_is_swi <= latch_swi_nxt;
      stack_index_high <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_TAKE_AT_BOUNDARY: assert property (int_take |-> $past(instr_boundary))
    else $error("take without boundary");
  AST_MASK_BLOCKS_HW: assert property (int_take && !grant_is_swi |-> $past(!global_mask))
    else $error("hardware take while masked");
  AST_SWI_IGNORES_MASK: assert property (state_r == IARB_IDLE && instr_boundary && swi_exec
    |=> int_take && grant_is_swi)
    else $error("swi not taken");
  AST_SWI_PC: assert property (int_take && grant_is_swi |-> stack_pc == $past(pc_in))
    else $error("swi stacked pc wrong");
  AST_HW_PC: assert property (int_take && !grant_is_swi |-> stack_pc == $past(pc_in) - 16'h0001)
    else $error("hw stacked pc wrong");
  AST_VEC_MAP: assert property (int_take && !grant_is_swi
    |-> vector_addr == 16'hFFFC - {10'h000, grant_idx, 1'b0})
    else $error("vector mismatch");
  AST_HOLD_GRANT: assert property (state_r == IARB_LATCHED && !service_ack
    |=> $stable(grant_idx))
    else $error("latched grant displaced");
  AST_STATUS_FOLLOWS: assert property (##1 reg_rd && reg_addr == IARB_OFS_STATUS_LOW
    |=> reg_rdata == {$past(irq_req[5:0], 2), 2'b00})
    else $error("status low wrong");
  AST_PRIORITY: assert property (int_take && !grant_is_swi && grant_idx > 5'h01
    |-> ($past(eligible) & ((21'h000001 << (grant_idx - 5'h01)) - 21'h000001)) == 21'h000000)
    else $error("lower priority granted");
  AST_NO_H_STACK: assert property (stack_index_high == 1'b0)
    else $error("high index stacked");

  // ----------------------------------------
  // entry, hold and register port checks
  // ----------------------------------------
  AST_TAKE_PULSE: assert property (int_take |=> !int_take)
    else $error("take longer than one cycle");
  AST_NO_TAKE_BUSY: assert property (state_r != IARB_IDLE |=> !int_take)
    else $error("take while a request is latched");
  AST_DISCARD_WITH_TAKE: assert property (discard_prefetch |-> int_take)
    else $error("discard without take");
  AST_FLAGS_FOLLOW: assert property ($past(resetn) |-> flags_r == $past(irq_req))
    else $error("flags do not follow requests");
  AST_SWI_VEC: assert property (int_take && grant_is_swi
    |-> vector_addr == IARB_VEC_SWI && grant_idx == IARB_IDX_NONE)
    else $error("swi vector wrong");
  AST_HW_IDX_RANGE: assert property (int_take && !grant_is_swi
    |-> grant_idx >= 5'h01 && grant_idx <= 5'h15)
    else $error("hardware index out of range");
  AST_TAKE_ENABLED: assert property (int_take && !grant_is_swi
    |-> (($past(eligible) >> (grant_idx - 5'h01)) & 21'h000001) == 21'h000001)
    else $error("granted source not pending and enabled");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_VEC_HELD: assert property (!int_take |-> $stable(vector_addr))
    else $error("vector changed without take");
  AST_GRANT_BIT_SET: assert property (int_take && !grant_is_swi |-> evt_r[IARB_EVT_GRANT_BIT])
    else $error("grant event not recorded");
  AST_SWI_BIT_SET: assert property (int_take && grant_is_swi |-> evt_r[IARB_EVT_SWI_BIT])
    else $error("swi event not recorded");

  COV_HW_TAKE: cover property (int_take && !grant_is_swi);
  COV_SWI_TAKE: cover property (int_take && grant_is_swi);
  COV_RETURN_PENDING: cover property (discard_prefetch);
  COV_IRQ: cover property (irq_out);

endmodule

// File: core/iarb_pkg.sv
// constants and types for the interrupt arbiter and vector selector
package iarb_pkg;
  localparam int IARB_NUM_SRC = 21;
  localparam logic [7:0] IARB_ADDR_WIDTH = 8'h08;
  // register offsets on the plain register port
  localparam logic [7:0] IARB_OFS_STATUS_LOW = 8'h00;
  localparam logic [7:0] IARB_OFS_STATUS_MID = 8'h01;
  localparam logic [7:0] IARB_OFS_STATUS_HIGH = 8'h02;
  localparam logic [7:0] IARB_OFS_ENABLE_0 = 8'h04;
  localparam logic [7:0] IARB_OFS_ENABLE_1 = 8'h05;
  localparam logic [7:0] IARB_OFS_ENABLE_2 = 8'h06;
  localparam logic [7:0] IARB_OFS_EVT_STATUS = 8'h08;
  localparam logic [7:0] IARB_OFS_EVT_MASK = 8'h09;
  // field positions
  localparam int IARB_LOW_FIRST_BIT = 2;
  localparam int IARB_EVT_GRANT_BIT = 0;
  localparam int IARB_EVT_SWI_BIT = 1;
  localparam int IARB_EVT_RESERVED_W = 6;
  // vectors
  localparam logic [15:0] IARB_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] IARB_VEC_SWI = 16'hFFFC;
  localparam logic [15:0] IARB_VEC_FLAG1 = 16'hFFFA;
  localparam logic [15:0] IARB_VEC_RESERVED = 16'hFFD0;
  // reset values
  localparam logic [20:0] IARB_ENABLE_RESET = 21'h000000;
  localparam logic [7:0] IARB_EVT_RESET = 8'h00;
  localparam logic [4:0] IARB_IDX_NONE = 5'h00;
  localparam logic [15:0] IARB_PC_RESET = 16'h0000;
  typedef enum logic [1:0] {IARB_IDLE, IARB_LATCHED, IARB_SERVICE} iarb_state_type;
endpackage

// File: dv/iarb_cpu_model.sv
// cpu core stand-in: instruction boundaries, service acknowledge, return
`timescale 1ns/1ps
module iarb_cpu_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic step,
  input wire logic software_interrupt_instr,
  input wire logic ret,
  input wire logic hold_mask,
  input wire logic int_take,
  output logic instr_boundary,
  output logic swi_exec,
  output logic rti_exec,
  output logic service_ack,
  output logic global_mask
);
  logic in_srv_r;
  // mask raised on entry and dropped again by the return
  assign global_mask = hold_mask | in_srv_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      instr_boundary <= 1'h0;
      swi_exec <= 1'h0;
      rti_exec <= 1'h0;
      service_ack <= 1'h0;
      in_srv_r <= 1'h0;
    end else begin
      instr_boundary <= step;
      swi_exec <= step & software_interrupt_instr;
      rti_exec <= ret;
      service_ack <= int_take;
      if (int_take) in_srv_r <= 1'h1;
      else if (ret) in_srv_r <= 1'h0;
    end
  end
endmodule

// File: dv/iarb_top_test.sv
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
module iarb_top_test;
  import iarb_pkg::*;
  typedef struct packed {logic [20:0] req; logic [20:0] en; logic [4:0] idx;} iarb_row_type;
  logic core_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic step = 1'h0, software_interrupt_instr = 1'h0, ret = 1'h0, hold_mask = 1'h0, got;
  logic [20:0] irq_req = 21'h0;
  logic [15:0] pc_in = 16'h0000, vector_addr, stack_pc;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [4:0] grant_idx;
  logic int_take, grant_is_swi, stack_index_high, discard_prefetch, irq_out;
  logic instr_boundary, swi_exec, rti_exec, service_ack, global_mask;
  int fails = 0, total_checks = 0;
  iarb_row_type rows [5] = '{'{21'h000001, 21'h1FFFFF, 5'h01}, '{21'h000024, 21'h1FFFFF, 5'h03},
    '{21'h100000, 21'h1FFFFF, 5'h15}, '{21'h000408, 21'h1FFFF7, 5'h0B}, '{21'h008080, 21'h1FFFFF, 5'h08}};
  iarb_top iarb_top_i (.core_clk, .resetn, .irq_req, .global_mask, .instr_boundary, .swi_exec,
    .rti_exec, .service_ack, .pc_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .int_take,
    .vector_addr, .grant_idx, .grant_is_swi, .stack_pc, .stack_index_high, .discard_prefetch, .irq_out);
  iarb_cpu_model iarb_cpu_model_i (.core_clk, .resetn, .step, .software_interrupt_instr, .ret, .hold_mask, .int_take,
    .instr_boundary, .swi_exec, .rti_exec, .service_ack, .global_mask);
  always #5 core_clk = ~core_clk;
  // ----------------------------------------
  // bus and handshake tasks
  // ----------------------------------------
  task test_done;
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
    @(posedge core_clk) reg_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'h1};
    @(posedge core_clk) reg_rd <= 1'h0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task en(input logic [20:0] e);
    wr(IARB_OFS_ENABLE_0, e[7:0]);
    wr(IARB_OFS_ENABLE_1, e[15:8]);
    wr(IARB_OFS_ENABLE_2, {3'h0, e[20:16]});
  endtask
  task bnd(input logic s, input logic [15:0] p);
    @(posedge core_clk) {step, software_interrupt_instr, pc_in} <= {1'h1, s, p};
    @(posedge core_clk) step <= 1'h0;
    got = 1'h0;
    for (int k = 0; k < 6 && got !== 1'h1; k++) begin
      @(posedge core_clk);
      #1 got = int_take;
    end
  endtask
  task take(input logic s, input logic [4:0] i, input logic d);
    logic [15:0] p;
    p = {11'h123, i};
    bnd(s, p);
    chk(got, 1'h1);
    chk(vector_addr, 16'hFFFC - {10'h000, i, 1'h0});
    chk(grant_idx, i);
    chk(grant_is_swi, s);
    chk(stack_pc, s ? p : p - 16'h0001);
    chk(stack_index_high, 1'h0);
    chk(discard_prefetch, d);
  endtask
  task idle;
    bnd(1'h0, 16'h0100);
    chk(got, 1'h0);
  endtask
  task ret_p;
    @(posedge core_clk) ret <= 1'h1;
    @(posedge core_clk) ret <= 1'h0;
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    #100000;
    fails++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    foreach (rows[n]) begin
      en(rows[n].en);
      @(posedge core_clk) irq_req <= rows[n].req;
      repeat (2) @(posedge core_clk);
      rd(IARB_OFS_STATUS_LOW, {rows[n].req[5:0], 2'h0});
      rd(IARB_OFS_STATUS_MID, rows[n].req[13:6]);
      rd(IARB_OFS_STATUS_HIGH, {1'h0, rows[n].req[20:14]});
      take(1'h0, rows[n].idx, 1'h0);
      @(posedge core_clk) irq_req <= 21'h0;
      ret_p;
      idle;
    end
    chk(irq_out, 1'h0);
    rd(IARB_OFS_EVT_STATUS, 8'h01);
    wr(IARB_OFS_EVT_STATUS, 8'h01);
    rd(IARB_OFS_EVT_STATUS, 8'h00);
    wr(IARB_OFS_EVT_MASK, 8'h03);
    // two pending: the second waits for the return, no displacement
    en(21'h1FFFFF);
    @(posedge core_clk) irq_req <= 21'h000003;
    repeat (2) @(posedge core_clk);
    take(1'h0, 5'h01, 1'h0);
    @(posedge core_clk) irq_req <= 21'h000002;
    idle;
    ret_p;
    take(1'h0, 5'h02, 1'h1);
    @(posedge core_clk) {irq_req, hold_mask} <= {21'h000010, 1'h1};
    ret_p;
    idle;
    take(1'h1, 5'h00, 1'h0);
    repeat (2) @(posedge core_clk);
    #1 chk(irq_out, 1'h1);
    rd(IARB_OFS_EVT_STATUS, 8'h03);
    wr(IARB_OFS_EVT_STATUS, 8'h03);
    repeat (2) @(posedge core_clk);
    #1 chk(irq_out, 1'h0);
    @(posedge core_clk) hold_mask <= 1'h0;
    ret_p;
    take(1'h0, 5'h05, 1'h1);
    @(posedge core_clk) irq_req <= 21'h0;
    ret_p;
    wr(IARB_OFS_STATUS_LOW, 8'hFF);
    rd(IARB_OFS_STATUS_LOW, 8'h00);
    rd(8'h03, 8'h00);
    rd(IARB_OFS_EVT_MASK, 8'h03);
    @(posedge core_clk) resetn <= 1'h0;
    @(posedge core_clk) resetn <= 1'h1;
    @(posedge core_clk);
    #1 chk(vector_addr, 16'hFFFE);
    rd(IARB_OFS_ENABLE_0, 8'h00);
    rd(IARB_OFS_EVT_STATUS, 8'h00);
    test_done;
  end
endmodule
